// file: hdl/etsg_pkg.sv
// Constants, states and register map of the trip and start guard block.
// Functional notes
// - External trip input on: enter trip, show E12, stop driving output.
// - Function code 12 latches a trip on the off-to-on edge only.
// - Dropping the trip input keeps the trip; only reset clears it.
// - On trip remove drive so the motor coasts; alarm on at once.
// - Reset released with run active and guard off resumes driving.
// - Guard on: cleared trip waits for fresh run edge or reset pulse.
// - Guard off: run active at power-up starts running at once.
// - Guard on and run active at power-up: no start, trip E13.
// - Guard trip cleared by reset terminal restarts if run active.
// - After E09 cleared by reset, guard check applies to active run.
// - Guard uses code 13; both functions fit any of six slots.
package etsg_pkg;
   localparam int NUM_SLOTS = 6;
   localparam int FUNC_W = 5;
   localparam logic [FUNC_W-1:0] FUNC_EXT_TRIP = 5'h0C;
   localparam logic [FUNC_W-1:0] FUNC_START_GUARD = 5'h0D;
   localparam logic [FUNC_W-1:0] FUNC_RESET_VAL = 5'h00;

   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] REG_SLOT_FUNC = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h08;
   localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h0C;
   localparam logic [ADDR_W-1:0] REG_HISTORY = 8'h10;

   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_UNDERVOLT = 8'h09;
   localparam logic [7:0] ERR_EXT_TRIP = 8'h0C;
   localparam logic [7:0] ERR_START_GUARD = 8'h0D;

   // Interrupt status and history bit positions
   localparam int EV_EXT = 0;
   localparam int EV_GUARD = 1;
   localparam int EV_UV = 2;
   localparam int EV_START = 3;
   localparam int NUM_EV = 4;
   localparam logic [NUM_EV-1:0] MASK_RESET_VAL = 4'h0;

   typedef enum logic [2:0] {
      etsg_pwrup, etsg_stop, etsg_run, etsg_trip, etsg_clear, etsg_hold
   } etsg_state_e;
endpackage : etsg_pkg

// file: hdl/etsg_guard.sv
// External trip latch and unattended start guard with register port.
`timescale 1ns/1ps
`default_nettype none
module etsg_guard (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Register port
   input wire logic [etsg_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Field inputs
   input wire logic [etsg_pkg::NUM_SLOTS-1:0] prog_in,
   input wire logic run_cmd,
   input wire logic reset_terminal,
   input wire logic keypad_reset,
   input wire logic undervolt,
   // Drive and alarm
   output logic drive_en,
   output logic alarm,
   output logic [7:0] error_code,
   output logic irq
);
   import etsg_pkg::*;

   etsg_state_e state, next_state;
   logic [FUNC_W*NUM_SLOTS-1:0] slot_func;
   logic [NUM_EV-1:0] irq_stat, irq_mask, history;
   logic [7:0] next_err, clear_cause;
   logic ext_prev, run_prev, rt_prev;

   // Slot decode: any slot may carry either function
   wire [NUM_SLOTS-1:0] ext_hit;
   wire [NUM_SLOTS-1:0] guard_hit;
   genvar g;
   generate
      for (g = 0; g < NUM_SLOTS; g++) begin : g_slot
         assign ext_hit[g] = prog_in[g] &&
            slot_func[g*FUNC_W +: FUNC_W] == FUNC_EXT_TRIP;
         assign guard_hit[g] = prog_in[g] &&
            slot_func[g*FUNC_W +: FUNC_W] == FUNC_START_GUARD;
      end
   endgenerate

   wire ext_active = |ext_hit;
   wire guard_en = |guard_hit;
   wire ext_rise = ext_active && !ext_prev;
   wire run_rise = run_cmd && !run_prev;
   // Both reset sources count as the same clear request
   wire clr_req = keypad_reset || (reset_terminal && !rt_prev);
   wire uv_new = undervolt && state != etsg_trip && state != etsg_clear;
   wire in_trip = state == etsg_trip || state == etsg_clear;

   // Trip and start sequencing
   always_comb begin
      next_state = state;
      next_err = error_code;
      if (ext_rise) begin
         next_state = etsg_trip;
         next_err = ERR_EXT_TRIP;
      end else if (uv_new) begin
         next_state = etsg_trip;
         next_err = ERR_UNDERVOLT;
      end else begin
         unique case (state)
            etsg_pwrup: begin
               if (run_cmd && guard_en) begin
                  next_state = etsg_trip;
                  next_err = ERR_START_GUARD;
               end else if (run_cmd) begin
                  next_state = etsg_run;
               end else begin
                  next_state = etsg_stop;
               end
            end
            etsg_stop: begin
               if (run_rise) begin
                  next_state = etsg_run;
               end
            end
            etsg_run: begin
               if (!run_cmd) begin
                  next_state = etsg_stop;
               end
            end
            etsg_trip: begin
               // Trip input level alone never clears it
               if (clr_req) begin
                  next_state = etsg_clear;
                  next_err = ERR_NONE;
               end else if (error_code == ERR_START_GUARD && !run_cmd) begin
                  next_state = etsg_stop;
                  next_err = ERR_NONE;
               end
            end
            etsg_clear: begin
               // Drive stays off until the reset terminal is released
               if (!reset_terminal) begin
                  if (!run_cmd) begin
                     next_state = etsg_stop;
                  end else if (clear_cause == ERR_START_GUARD ||
                               clear_cause == ERR_NONE) begin
                     next_state = etsg_run;
                  end else if (clear_cause == ERR_UNDERVOLT && guard_en) begin
                     next_state = etsg_trip;
                     next_err = ERR_START_GUARD;
                  end else if (guard_en) begin
                     next_state = etsg_hold;
                  end else begin
                     next_state = etsg_run;
                  end
               end
            end
            etsg_hold: begin
               if (!run_cmd) begin
                  next_state = etsg_stop;
               end else if (run_rise) begin
                  next_state = etsg_run;
               end else if (clr_req) begin
                  next_state = etsg_clear;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         state <= etsg_pwrup;
         error_code <= ERR_NONE;
      end else begin
         state <= next_state;
         error_code <= next_err;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         clear_cause <= ERR_NONE;
      end else if (state == etsg_trip && clr_req) begin
         clear_cause <= error_code;
      end else if (state == etsg_hold && clr_req) begin
         clear_cause <= ERR_NONE;
      end
   end

   // Edge history; the trip input counts as off before power-up
   always_ff @(posedge mclk) begin
      if (srst) begin
         ext_prev <= 1'b0;
         run_prev <= 1'b0;
         rt_prev <= 1'b0;
      end else begin
         ext_prev <= ext_active;
         run_prev <= run_cmd;
         rt_prev <= reset_terminal;
      end
   end

   // Coast: no drive in any trip or clearing state
   assign drive_en = state == etsg_run;
   assign alarm = in_trip;

   // Events
   wire [NUM_EV-1:0] ev;
   assign ev[EV_EXT] = ext_rise;
   assign ev[EV_GUARD] = next_state == etsg_trip &&
      next_err == ERR_START_GUARD && state != etsg_trip;
   assign ev[EV_UV] = uv_new && !ext_rise;
   assign ev[EV_START] = next_state == etsg_run && state != etsg_run;

   // Register decode
   wire wr_func = reg_wr && reg_addr == REG_SLOT_FUNC;
   wire wr_istat = reg_wr && reg_addr == REG_IRQ_STAT;
   wire wr_imask = reg_wr && reg_addr == REG_IRQ_MASK;
   wire [NUM_EV-1:0] w1c = wr_istat ? reg_wdata[NUM_EV-1:0] : '0;
   wire [31:0] status_word = {16'h0000, error_code, 4'h0,
      guard_en, alarm, drive_en, run_cmd};
   wire [31:0] rd_mux =
      reg_addr == REG_SLOT_FUNC ? {2'b00, slot_func} :
      reg_addr == REG_STATUS ? status_word :
      reg_addr == REG_IRQ_STAT ? {28'h0000000, irq_stat} :
      reg_addr == REG_IRQ_MASK ? {28'h0000000, irq_mask} :
      reg_addr == REG_HISTORY ? {28'h0000000, history} : 32'h00000000;

   // Slot settings survive reset, else the power-up check never sees the guard
   always_ff @(posedge mclk) begin
      if (wr_func) begin
         slot_func <= reg_wdata[FUNC_W*NUM_SLOTS-1:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         irq_mask <= MASK_RESET_VAL;
         irq_stat <= '0;
         history <= '0;
         reg_rdata <= 32'h00000000;
      end else begin
         if (wr_imask) begin
            irq_mask <= reg_wdata[NUM_EV-1:0];
         end
         // New event wins over a same-cycle clear
         irq_stat <= (irq_stat & ~w1c) | ev;
         history <= (clr_req ? '0 : history) | ev;
         reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
      end
   end

   assign irq = |(irq_stat & irq_mask);

   // Checks
   property p_ext_trip;
      @(posedge mclk) disable iff (srst)
      ext_rise |=> alarm && !drive_en && error_code == ERR_EXT_TRIP;
   endproperty
   a_ext_trip: assert property (p_ext_trip)
      else $error("external trip not latched");

   property p_hold_trip;
      @(posedge mclk) disable iff (srst)
      (state == etsg_trip && !clr_req && error_code == ERR_EXT_TRIP)
         |=> state == etsg_trip;
   endproperty
   a_hold_trip: assert property (p_hold_trip)
      else $error("trip cleared without reset");

   property p_fall_no_trip;
      @(posedge mclk) disable iff (srst)
      (state inside {etsg_stop, etsg_run, etsg_hold} && $fell(ext_active) &&
       !undervolt && !clr_req) |=> !alarm;
   endproperty
   a_fall_no_trip: assert property (p_fall_no_trip)
      else $error("trip on falling input");

   property p_off_while_tripped;
      @(posedge mclk) disable iff (srst)
      error_code != ERR_NONE |-> alarm && !drive_en;
   endproperty
   a_off_while_tripped: assert property (p_off_while_tripped)
      else $error("drive on while tripped");

   property p_resume;
      @(posedge mclk) disable iff (srst)
      (state == etsg_clear && !reset_terminal && run_cmd && !guard_en &&
       clear_cause == ERR_EXT_TRIP && !ext_rise && !undervolt)
         |=> drive_en;
   endproperty
   a_resume: assert property (p_resume)
      else $error("no resume after reset release");

   property p_guard_hold;
      @(posedge mclk) disable iff (srst)
      (state == etsg_clear && !reset_terminal && run_cmd && guard_en &&
       clear_cause == ERR_EXT_TRIP && !ext_rise && !undervolt)
         |=> !drive_en ##1 (!drive_en || $past(run_rise) || $past(clr_req));
   endproperty
   a_guard_hold: assert property (p_guard_hold)
      else $error("guard restarted without fresh command");

   property p_pwr_run;
      @(posedge mclk) disable iff (srst)
      (state == etsg_pwrup && run_cmd && !guard_en && !ext_rise &&
       !undervolt) |=> drive_en;
   endproperty
   a_pwr_run: assert property (p_pwr_run)
      else $error("no start at power-up");

   property p_pwr_guard;
      @(posedge mclk) disable iff (srst)
      (state == etsg_pwrup && run_cmd && guard_en && !ext_rise &&
       !undervolt) |=> alarm && error_code == ERR_START_GUARD;
   endproperty
   a_pwr_guard: assert property (p_pwr_guard)
      else $error("guard did not trip at power-up");

   property p_guard_reset;
      @(posedge mclk) disable iff (srst)
      (state == etsg_clear && !reset_terminal && run_cmd &&
       clear_cause == ERR_START_GUARD && !ext_rise && !undervolt)
         |=> drive_en;
   endproperty
   a_guard_reset: assert property (p_guard_reset)
      else $error("no restart after guard reset");

   property p_uv_guard;
      @(posedge mclk) disable iff (srst)
      (state == etsg_clear && !reset_terminal && run_cmd && guard_en &&
       clear_cause == ERR_UNDERVOLT && !ext_rise && !undervolt)
         |=> alarm && error_code == ERR_START_GUARD;
   endproperty
   a_uv_guard: assert property (p_uv_guard)
      else $error("guard skipped after undervoltage");

   property p_guard_drop;
      @(posedge mclk) disable iff (srst)
      (state == etsg_trip && error_code == ERR_START_GUARD && !run_cmd &&
       !clr_req && !ext_rise) |=> !alarm && error_code == ERR_NONE;
   endproperty
   a_guard_drop: assert property (p_guard_drop)
      else $error("guard alarm kept after run dropped");
endmodule : etsg_guard
`default_nettype wire

// file: dv/etsg_field_model.sv
// Field side model: contacts, reset terminal, keypad and run source.
`timescale 1ns/1ps
`default_nettype none
module etsg_field_model #(
   parameter int TERM_LEN = 3
) (
   // Clock
   input wire logic mclk,
   // Bench requests
   input wire logic [2:0] ext_slot,
   input wire logic [2:0] guard_slot,
   input wire logic [5:0] noise,
   input wire logic ext_on,
   input wire logic guard_on,
   input wire logic run_on,
   input wire logic uv_on,
   input wire logic key_req,
   input wire logic term_req,
   // Field lines
   output logic [etsg_pkg::NUM_SLOTS-1:0] prog_in,
   output logic run_cmd,
   output logic reset_terminal,
   output logic keypad_reset,
   output logic undervolt
);
   import etsg_pkg::*;
   int term_cnt = 0;
   logic [NUM_SLOTS-1:0] fixed;
   // Noise never reaches the trip or guard slot, so only requested edges trip
   assign fixed = (NUM_SLOTS'(1) << ext_slot) | (NUM_SLOTS'(1) << guard_slot);
   always @(posedge mclk) begin
      prog_in <= (noise & ~fixed) | (NUM_SLOTS'(ext_on) << ext_slot)
         | (NUM_SLOTS'(guard_on) << guard_slot);
      run_cmd <= run_on;
      undervolt <= uv_on;
      // Key is a single press; terminal is held as a person would hold it
      keypad_reset <= key_req;
      if (term_req) begin
         term_cnt <= TERM_LEN;
      end else if (term_cnt > 0) begin
         term_cnt <= term_cnt - 1;
      end
      reset_terminal <= term_req || term_cnt > 1;
   end
endmodule : etsg_field_model
`default_nettype wire

// file: dv/test_external_trip_start_guard.sv
// Self-checking bench of the trip latch and start guard block.
`timescale 1ns/1ps
`default_nettype none
module test_external_trip_start_guard;
   import etsg_pkg::*;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [NUM_SLOTS-1:0] prog_in;
   logic run_cmd, reset_terminal, keypad_reset, undervolt;
   logic drive_en, alarm, irq;
   logic [7:0] error_code;
   logic [2:0] ext_slot = 3'h0;
   logic [2:0] guard_slot = 3'h1;
   logic [5:0] noise = 6'h00;
   logic ext_on = 1'b0, guard_on = 1'b0, run_on = 1'b1, uv_on = 1'b0;
   logic key_req = 1'b0, term_req = 1'b0, use_key;
   logic [31:0] seed = 32'h0000001D;
   logic [31:0] word, r;
   int miscompares = 0;
   int n_compared = 0;

   always #2 mclk = ~mclk;

   etsg_guard i_etsg_guard (
      .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .prog_in(prog_in), .run_cmd(run_cmd), .reset_terminal(reset_terminal),
      .keypad_reset(keypad_reset), .undervolt(undervolt),
      .drive_en(drive_en), .alarm(alarm), .error_code(error_code), .irq(irq)
   );
   etsg_field_model #(.TERM_LEN(3)) i_etsg_field_model (
      .mclk(mclk), .ext_slot(ext_slot), .guard_slot(guard_slot),
      .noise(noise), .ext_on(ext_on), .guard_on(guard_on), .run_on(run_on),
      .uv_on(uv_on), .key_req(key_req), .term_req(term_req),
      .prog_in(prog_in), .run_cmd(run_cmd), .reset_terminal(reset_terminal),
      .keypad_reset(keypad_reset), .undervolt(undervolt)
   );

   function automatic logic [31:0] next_rand();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : next_rand

   // Unused slots get random codes below the two guarded functions
   function automatic logic [31:0] slot_word(input int external_trip_input, input int grd,
                                             input logic [31:0] fill);
      logic [31:0] w;
      w = '0;
      for (int j = 0; j < NUM_SLOTS; j++) begin
         if (j == external_trip_input) w[5*j +: 5] = FUNC_EXT_TRIP;
         else if (j == grd) w[5*j +: 5] = FUNC_START_GUARD;
         else w[5*j +: 5] = {1'b0, fill[4*j +: 4] % 4'hC};
      end
      return w;
   endfunction : slot_word

   function automatic logic [31:0] status_word(input logic run, drv, al, grd,
                                               input logic [7:0] err);
      return {16'h0000, err, 4'h0, grd, al, drv, run};
   endfunction : status_word

   task automatic give_verdict();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : step

   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [ADDR_W-1:0] a);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      r = reg_rdata;
   endtask : rd_reg

   task automatic clear_req(input logic by_key);
      @(posedge mclk);
      if (by_key) key_req <= 1'b1;
      else term_req <= 1'b1;
      @(posedge mclk);
      key_req <= 1'b0;
      term_req <= 1'b0;
   endtask : clear_req

   // Bounded wait for drive, alarm and code; a hang ends the run
   task automatic wait_outs(input logic d, a, input logic [7:0] e);
      int k;
      k = 0;
      // Never judge in the time step of the edge that launches the change
      #1;
      while ({drive_en, alarm, error_code} !== {d, a, e} && k < 12) begin
         step(1);
         k++;
      end
      check("outputs", {drive_en, alarm, error_code}, {d, a, e});
      if ({drive_en, alarm, error_code} !== {d, a, e}) give_verdict();
   endtask : wait_outs

   initial begin
      step(11);
      check("reset", {drive_en, alarm, error_code, irq}, 11'h000);
      @(posedge mclk);
      srst <= 1'b0;
      wait_outs(1'b1, 1'b0, ERR_NONE);
      rd_reg(REG_STATUS);
      check("status", r, status_word(1, 1, 0, 0, ERR_NONE));
      rd_reg(8'h14);
      check("unmapped", r, 32'h0);
      for (int i = 0; i < NUM_SLOTS; i++) begin
         r = next_rand();
         word = slot_word(i, (i + 1) % NUM_SLOTS, r);
         use_key = r[30];
         @(posedge mclk);
         noise <= 6'h00;
         wr_reg(REG_SLOT_FUNC, word);
         @(posedge mclk);
         ext_slot <= 3'(i);
         guard_slot <= 3'((i + 1) % NUM_SLOTS);
         noise <= r[29:24];
         ext_on <= 1'b1;
         step(2);
         check("trip", {drive_en, alarm, error_code}, 10'h10C);
         check("irq", irq, i != 0);
         rd_reg(REG_SLOT_FUNC);
         check("slots", r, word);
         rd_reg(REG_HISTORY);
         check("hist_set", r[EV_EXT], 1'b1);
         if (i % 2 == 0) begin
            @(posedge mclk);
            ext_on <= 1'b0;
            step(4);
            check("held", {drive_en, alarm}, 2'b01);
         end
         clear_req(use_key);
         wait_outs(1'b1, 1'b0, ERR_NONE);
         @(posedge mclk);
         ext_on <= 1'b0;
         step(4);
         check("fall", {drive_en, alarm}, 2'b10);
         rd_reg(REG_HISTORY);
         check("hist_clr", r[EV_EXT], 1'b0);
         wr_reg(REG_IRQ_STAT, 32'h0000000F);
         wr_reg(REG_IRQ_MASK, 32'h0000000F);
         step(1);
         check("irq_clr", irq, 1'b0);
      end
      @(posedge mclk);
      guard_on <= 1'b1;
      ext_on <= 1'b1;
      wait_outs(1'b0, 1'b1, ERR_EXT_TRIP);
      rd_reg(REG_STATUS);
      check("status_g", r, status_word(1, 0, 1, 1, ERR_EXT_TRIP));
      clear_req(1'b1);
      wait_outs(1'b0, 1'b0, ERR_NONE);
      step(6);
      check("no_restart", drive_en, 1'b0);
      @(posedge mclk);
      run_on <= 1'b0;
      ext_on <= 1'b0;
      step(3);
      @(posedge mclk);
      run_on <= 1'b1;
      wait_outs(1'b1, 1'b0, ERR_NONE);
      // Held guard restart by a terminal pulse instead of a run edge
      @(posedge mclk);
      ext_on <= 1'b1;
      wait_outs(1'b0, 1'b1, ERR_EXT_TRIP);
      clear_req(1'b1);
      wait_outs(1'b0, 1'b0, ERR_NONE);
      clear_req(1'b0);
      wait_outs(1'b1, 1'b0, ERR_NONE);
      for (int k = 0; k < 2; k++) begin
         @(posedge mclk);
         uv_on <= 1'b1;
         wait_outs(1'b0, 1'b1, ERR_UNDERVOLT);
         @(posedge mclk);
         uv_on <= 1'b0;
         clear_req(1'b0);
         wait_outs(1'b0, 1'b1, ERR_START_GUARD);
         if (k == 0) begin
            clear_req(1'b0);
         end else begin
            @(posedge mclk);
            run_on <= 1'b0;
         end
         wait_outs(k == 0, 1'b0, ERR_NONE);
      end
      @(posedge mclk);
      run_on <= 1'b1;
      wait_outs(1'b1, 1'b0, ERR_NONE);
      // Mid-run reset with guard on and run held: power-up guard trip
      @(posedge mclk);
      ext_on <= 1'b0;
      srst <= 1'b1;
      step(3);
      check("reset2", {drive_en, alarm, error_code}, 10'h000);
      @(posedge mclk);
      srst <= 1'b0;
      wait_outs(1'b0, 1'b1, ERR_START_GUARD);
      clear_req(1'b1);
      wait_outs(1'b1, 1'b0, ERR_NONE);
      give_verdict();
   end
endmodule : test_external_trip_start_guard
`default_nettype wire
